/* File: hdl/nand_bus_front.sv */
// nand target bus front end: pin handling, output path, busy, protect
// assumes a core on clk_in supplies output bytes and array activity
`timescale 1ns/100ps

// Behaviour
// - address strobe latches lanes as address
// - command strobe latches lanes as command
// - chip enable gates all bus activity
// - one lane set carries all byte kinds
// - data strobe times data in sync mode
// - async read strobe pulse puts next byte
// - sync direction input steers lanes and strobe
// - async write strobe moves one byte in
// - sync cmd and addr latched on clock
// - write protect level gates program and erase
// - busy pulled low, never driven high
// - busy while any array activity runs
// - sync mode repurposes write and read pins
// - shared bus is eight bits wide
// - data strobe released in async mode
module nand_bus_front (
  // core clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    resetn_in,
  // link clock: write strobe or host clock pin
  input  wire logic                    link_clk_in,
  // host control pins
  input  wire logic                    ce_n_in,
  input  wire logic                    cle_in,
  input  wire logic                    ale_in,
  input  wire logic                    read_strobe_n_in,
  input  wire logic                    wp_n_in,
  // byte lanes
  input  wire logic [nand_bus_pkg::BUS_W-1:0] byte_lanes_in,
  output logic [nand_bus_pkg::BUS_W-1:0]      byte_lanes_out,
  output logic                         byte_lanes_oe_n_out,
  // data strobe
  input  wire logic                    dqs_in,
  output logic                         dqs_out,
  output logic                         dqs_oe_n_out,
  // ready/busy open drain
  output logic                         rb_out,
  output logic                         rb_oe_n_out,
  // core side: mode and received bytes
  input  wire logic                    sync_mode_in,
  output nand_bus_pkg::lane_byte_s     rx_out,
  output logic                         rx_valid_out,
  // core side: output bytes
  input  wire logic [nand_bus_pkg::BUS_W-1:0] dout_byte_in,
  output logic                         dout_take_out,
  // core side: array activity and protection
  input  wire logic                    array_busy_in,
  input  wire logic                    prog_erase_req_in,
  output logic                         prog_erase_go_out,
  output logic                         prog_erase_reject_out,
  output logic                         write_protected_out
);
  import nand_bus_pkg::*;

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  lane_byte_s       link_hold;
  logic             link_tog;
  pin_s             raw;
  pin_s             sy;

  out_state_e       state_ff, nxt_state;
  logic             rd_prev_ff;
  logic             lk_prev_ff;
  logic             tog_prev_ff;
  logic [BUS_W-1:0] lanes_ff, nxt_lanes;
  logic             lanes_oe_n_ff, nxt_lanes_oe_n;
  logic             dqs_ff, nxt_dqs;
  logic             dqs_oe_n_ff, nxt_dqs_oe_n;
  logic             take_ff, nxt_take;
  lane_byte_s       rx_ff, nxt_rx;
  logic             rx_valid_ff, nxt_rx_valid;
  logic             go_ff, nxt_go;
  logic             reject_ff, nxt_reject;
  logic             rb_oe_n_ff, nxt_rb_oe_n;
  logic             rb_ff;
  logic             prot_ff, nxt_prot;

  logic             sel;
  logic             rd_fall;
  logic             lk_rise;
  logic             tog_edge;

  // --------------------------------------------------------------
  // link domain capture
  // --------------------------------------------------------------
  nand_link_capture u_link (
    .link_clk_in  (link_clk_in),
    .resetn_in    (resetn_in),
    .sync_mode_in (sync_mode_in),
    .ce_n_in      (ce_n_in),
    .cle_in       (cle_in),
    .ale_in       (ale_in),
    .dir_in       (read_strobe_n_in),
    .dqs_in       (dqs_in),
    .lanes_in     (byte_lanes_in),
    .hold_out     (link_hold),
    .toggle_out   (link_tog)
  );

  // --------------------------------------------------------------
  // pin and crossing synchronisers
  // --------------------------------------------------------------
  assign raw = '{ce_n: ce_n_in,
                 rd_n: read_strobe_n_in,
                 wp_n: wp_n_in,
                 lclk: link_clk_in,
                 tog:  link_tog};

  bit_sync #(.W($bits(pin_s)), .RST_VAL(PINS_RST)) u_pins (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .d_in      (raw),
    .q_out     (sy)
  );

  assign sel      = !sy.ce_n;
  assign rd_fall  = rd_prev_ff && !sy.rd_n;
  assign lk_rise  = !lk_prev_ff && sy.lclk;
  assign tog_edge = tog_prev_ff != sy.tog;

  // --------------------------------------------------------------
  // output path state
  // --------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (sel && !sy.rd_n) begin
          nxt_state = sync_mode_in ? ST_SOUT : ST_AOUT;
        end
      end
      ST_AOUT: begin
        if (!sel || sy.rd_n || sync_mode_in) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_SOUT: begin
        if (!sel || sy.rd_n || !sync_mode_in) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  // --------------------------------------------------------------
  // output bytes and strobe
  // --------------------------------------------------------------
  always_comb begin
    nxt_take = 1'b0;
    nxt_dqs  = dqs_ff;
    if (sel && !sync_mode_in && rd_fall) begin
      nxt_take = 1'b1;
    end else if (state_ff == ST_SOUT && nxt_state == ST_SOUT
                 && lk_rise) begin
      nxt_take = 1'b1;
      nxt_dqs  = ~dqs_ff;
    end
    if (nxt_state != ST_SOUT) begin
      nxt_dqs = DQS_RST;
    end
    nxt_lanes      = nxt_take ? dout_byte_in : lanes_ff;
    nxt_lanes_oe_n = (nxt_state == ST_IDLE);
    nxt_dqs_oe_n   = (nxt_state != ST_SOUT);
  end

  // --------------------------------------------------------------
  // received bytes to the core
  // --------------------------------------------------------------
  always_comb begin
    nxt_rx       = rx_ff;
    nxt_rx_valid = 1'b0;
    if (tog_edge) begin
      nxt_rx       = link_hold;
      nxt_rx_valid = 1'b1;
    end
  end

  // --------------------------------------------------------------
  // protection and busy
  // --------------------------------------------------------------
  always_comb begin
    nxt_prot    = !sy.wp_n;
    nxt_go      = prog_erase_req_in && sy.wp_n;
    nxt_reject  = prog_erase_req_in && !sy.wp_n;
    nxt_rb_oe_n = !(array_busy_in || go_ff);
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff      <= ST_IDLE;
      rd_prev_ff    <= PIN_HI;
      lk_prev_ff    <= PIN_HI;
      tog_prev_ff   <= TOG_RST;
      lanes_ff      <= LANES_RST;
      lanes_oe_n_ff <= OE_OFF;
      dqs_ff        <= DQS_RST;
      dqs_oe_n_ff   <= OE_OFF;
      take_ff       <= 1'b0;
      rx_ff         <= '{kind: KIND_CMD, data: LANES_RST};
      rx_valid_ff   <= 1'b0;
      go_ff         <= 1'b0;
      reject_ff     <= 1'b0;
      rb_oe_n_ff    <= OE_OFF;
      rb_ff         <= RB_LOW;
      prot_ff       <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      rd_prev_ff    <= sy.rd_n;
      lk_prev_ff    <= sy.lclk;
      tog_prev_ff   <= sy.tog;
      lanes_ff      <= nxt_lanes;
      lanes_oe_n_ff <= nxt_lanes_oe_n;
      dqs_ff        <= nxt_dqs;
      dqs_oe_n_ff   <= nxt_dqs_oe_n;
      take_ff       <= nxt_take;
      rx_ff         <= nxt_rx;
      rx_valid_ff   <= nxt_rx_valid;
      go_ff         <= nxt_go;
      reject_ff     <= nxt_reject;
      rb_oe_n_ff    <= nxt_rb_oe_n;
      rb_ff         <= RB_LOW;
      prot_ff       <= nxt_prot;
    end
  end

  assign byte_lanes_out        = lanes_ff;
  assign byte_lanes_oe_n_out   = lanes_oe_n_ff;
  assign dqs_out               = dqs_ff;
  assign dqs_oe_n_out          = dqs_oe_n_ff;
  assign rb_out                = rb_ff;
  assign rb_oe_n_out           = rb_oe_n_ff;
  assign rx_out                = rx_ff;
  assign rx_valid_out          = rx_valid_ff;
  assign dout_take_out         = take_ff;
  assign prog_erase_go_out     = go_ff;
  assign prog_erase_reject_out = reject_ff;
  assign write_protected_out   = prot_ff;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_async_fall;
    !sync_mode_in && sel && rd_fall;
  endsequence

  sequence s_sync_write_dir;
    sync_mode_in && sel && sy.rd_n;
  endsequence

  AST_RB_NEVER_HIGH: assert property (
    !rb_oe_n_out |-> (rb_out == 1'b0)
  ) else $error("ready/busy driven high");

  AST_BUSY_SHOWN: assert property (
    array_busy_in |=> !rb_oe_n_out
  ) else $error("busy not shown during array activity");

  AST_READY_SHOWN: assert property (
    (!array_busy_in && !go_ff) |=> rb_oe_n_out
  ) else $error("busy shown while idle");

  AST_WP_BLOCKS: assert property (
    (prog_erase_req_in && !sy.wp_n) |=>
      !prog_erase_go_out && prog_erase_reject_out
  ) else $error("protected operation not blocked");

  AST_WP_PERMITS: assert property (
    (prog_erase_req_in && sy.wp_n) |=> prog_erase_go_out ##1 !rb_oe_n_out
  ) else $error("permitted operation not started");

  AST_ASYNC_READ: assert property (
    s_async_fall |=> dout_take_out && !byte_lanes_oe_n_out
      && (byte_lanes_out == $past(dout_byte_in))
  ) else $error("read strobe did not present a byte");

  AST_SYNC_DIR: assert property (
    s_sync_write_dir |=> byte_lanes_oe_n_out && dqs_oe_n_out
  ) else $error("device drove lanes in write direction");

  AST_DQS_HIZ: assert property (
    !sync_mode_in [*2] |-> dqs_oe_n_out
  ) else $error("data strobe driven in async mode");

  AST_RX_DELIVER: assert property (
    tog_edge |=> rx_valid_out && (rx_out == $past(link_hold))
  ) else $error("captured byte not delivered");

endmodule

/* File: hdl/nand_bus_pkg.sv */
// constants and carriers for the nand bus signal front end
// assumes one core clock and one host-driven link clock
package nand_bus_pkg;

  // --------------------------------------------------------------
  // widths and values after reset
  // --------------------------------------------------------------
  localparam int         BUS_W     = 8;
  localparam logic [7:0] LANES_RST = 8'h00;
  localparam logic       RB_LOW    = 1'b0;
  localparam logic       OE_OFF    = 1'b1;
  localparam logic       DQS_RST   = 1'b0;
  localparam logic       TOG_RST   = 1'b0;
  localparam logic       PIN_HI    = 1'b1;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_CMD  = 2'h0,
    KIND_ADDR = 2'h1,
    KIND_DATA = 2'h2
  } byte_kind_e;

  typedef struct packed {
    byte_kind_e       kind;
    logic [BUS_W-1:0] data;
  } lane_byte_s;

  typedef struct packed {
    logic ce_n;
    logic rd_n;
    logic wp_n;
    logic lclk;
    logic tog;
  } pin_s;

  // synchronised pins start at their idle levels
  localparam pin_s PINS_RST = '{ce_n: PIN_HI, rd_n: PIN_HI, wp_n: PIN_HI,
                                lclk: PIN_HI, tog: TOG_RST};

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_AOUT = 3'h2,
    ST_SOUT = 3'h4
  } out_state_e;

endpackage

/* File: hdl/bit_sync.sv */
// two-stage synchroniser for a group of level signals
// assumes each bit is a level that holds for several clocks
`timescale 1ns/100ps
module bit_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  // levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // first stage read only by the second
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end else begin
      meta_ff <= d_in;
      q_ff    <= meta_ff;
    end
  end

  assign q_out = q_ff;

endmodule

/* File: hdl/nand_link_capture.sv */
// link-clock side: latches command, address and input data bytes
// assumes the write strobe or host clock pin drives link_clk_in
`timescale 1ns/100ps
module nand_link_capture (
  // link clock and reset
  input  wire logic                    link_clk_in,
  input  wire logic                    resetn_in,
  // mode from core domain
  input  wire logic                    sync_mode_in,
  // host pins
  input  wire logic                    ce_n_in,
  input  wire logic                    cle_in,
  input  wire logic                    ale_in,
  input  wire logic                    dir_in,
  input  wire logic                    dqs_in,
  input  wire logic [7:0]              lanes_in,
  // to core domain
  output nand_bus_pkg::lane_byte_s     hold_out,
  output logic                         toggle_out
);
  import nand_bus_pkg::*;

  logic       mode_s;
  lane_byte_s hold_ff, nxt_hold;
  logic       tog_ff, nxt_tog;
  logic       dqs_prev_ff;

  bit_sync #(.W(1)) u_mode (
    .clk_in    (link_clk_in),
    .resetn_in (resetn_in),
    .d_in      (sync_mode_in),
    .q_out     (mode_s)
  );

  // --------------------------------------------------------------
  // byte classification on each link edge
  // --------------------------------------------------------------
  always_comb begin
    nxt_hold = hold_ff;
    nxt_tog  = tog_ff;
    if (!ce_n_in && !(cle_in && ale_in)) begin
      if (cle_in) begin
        nxt_hold = '{kind: KIND_CMD, data: lanes_in};
        nxt_tog  = ~tog_ff;
      end else if (ale_in) begin
        nxt_hold = '{kind: KIND_ADDR, data: lanes_in};
        nxt_tog  = ~tog_ff;
      end else if (!mode_s) begin
        nxt_hold = '{kind: KIND_DATA, data: lanes_in};
        nxt_tog  = ~tog_ff;
      end else if (dir_in && (dqs_in != dqs_prev_ff)) begin
        nxt_hold = '{kind: KIND_DATA, data: lanes_in};
        nxt_tog  = ~tog_ff;
      end
    end
  end

  always_ff @(posedge link_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hold_ff     <= '{kind: KIND_CMD, data: LANES_RST};
      tog_ff      <= TOG_RST;
      dqs_prev_ff <= DQS_RST;
    end else begin
      hold_ff     <= nxt_hold;
      tog_ff      <= nxt_tog;
      dqs_prev_ff <= dqs_in;
    end
  end

  assign hold_out   = hold_ff;
  assign toggle_out = tog_ff;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  AST_ADDR_CAPTURE: assert property (
    @(posedge link_clk_in) disable iff (!resetn_in)
    (!ce_n_in && ale_in && !cle_in) |=>
      (hold_ff.kind == KIND_ADDR) && (hold_ff.data == $past(lanes_in))
  ) else $error("address byte not latched");

  AST_CMD_CAPTURE: assert property (
    @(posedge link_clk_in) disable iff (!resetn_in)
    (!ce_n_in && cle_in && !ale_in) |=>
      (hold_ff.kind == KIND_CMD) && (tog_ff != $past(tog_ff))
  ) else $error("command byte not latched");

  AST_CE_IGNORE: assert property (
    @(posedge link_clk_in) disable iff (!resetn_in)
    ce_n_in |=> $stable(tog_ff) && $stable(hold_ff)
  ) else $error("deselected target took a byte");

endmodule

/* File: verif/nand_host_model.sv */
// behavioural host flash controller on the shared byte bus
// assumes the bench resolves shared wires from the device enables
`timescale 1ns/100ps
module nand_host_model (
  // core clock for pacing
  input  wire logic       clk_in,
  // host pins
  output logic            link_clk_out,
  output logic            ce_n_out,
  output logic            cle_out,
  output logic            ale_out,
  output logic            rd_n_out,
  output logic [7:0]      lanes_out,
  output logic            lanes_oe_n_out,
  output logic            dqs_out,
  output logic            dqs_oe_n_out
);
  import nand_bus_pkg::*;

  initial begin
    link_clk_out   = 1'b1;
    ce_n_out       = 1'b1;
    cle_out        = 1'b0;
    ale_out        = 1'b0;
    rd_n_out       = 1'b1;
    lanes_out      = 8'h00;
    lanes_oe_n_out = 1'b1;
    dqs_out        = 1'b0;
    dqs_oe_n_out   = 1'b1;
  end

  // one strobe cycle; clock stands high between frames
  task automatic pulse();
    #62.5 link_clk_out = 1'b0;
    #62.5 link_clk_out = 1'b1;
  endtask

  task automatic wr(input byte_kind_e k, input logic [7:0] d,
                    input logic sel_n);
    @(posedge clk_in) #1;
    ce_n_out       = sel_n;
    cle_out        = (k == KIND_CMD);
    ale_out        = (k == KIND_ADDR);
    lanes_out      = d;
    lanes_oe_n_out = 1'b0;
    if (k == KIND_DATA) dqs_out = ~dqs_out;
    pulse();
    #5;
    cle_out        = 1'b0;
    ale_out        = 1'b0;
    lanes_oe_n_out = 1'b1;
    lanes_out      = ~d;
    ce_n_out       = 1'b1;
  endtask

  // sync direction: 1 host writes, 0 device drives
  task automatic set_dir(input logic host_wr);
    @(posedge clk_in) #1;
    ce_n_out     = 1'b0;
    rd_n_out     = host_wr;
    dqs_oe_n_out = ~host_wr;
    if (!host_wr) dqs_out = ~dqs_out;
  endtask

  task automatic rd(input logic lvl);
    @(posedge clk_in) #1;
    ce_n_out = 1'b0;
    rd_n_out = lvl;
  endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench for the nand bus front end
// assumes the host model paces its pins off the core clock
`timescale 1ns/100ps
module tb;
  import nand_bus_pkg::*;

  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic       clk, resetn, link, ce_n, cle, ale, rd_n;
  logic       h_oe_n, h_dqs, h_dqs_oe_n, wp_n, sync_mode;
  logic       busy, req, d_oe_n, d_dqs, d_dqs_oe_n, rb, rb_oe_n;
  logic       rx_v, take, go, rej, wprot;
  logic [7:0] h_lanes, d_lanes, dout, lanes_w;
  logic       dqs_w, rb_w;
  lane_byte_s rx;
  int         error_cnt = 0;
  int         checks_done = 0;

  assign lanes_w = (d_oe_n == 1'b0) ? d_lanes : h_lanes;
  assign dqs_w   = (d_dqs_oe_n == 1'b0) ? d_dqs : h_dqs;
  assign rb_w    = (rb_oe_n == 1'b0) ? rb : 1'b1;

  nand_bus_front nand_bus_front_i (
    .clk_in(clk), .resetn_in(resetn), .link_clk_in(link),
    .ce_n_in(ce_n), .cle_in(cle), .ale_in(ale),
    .read_strobe_n_in(rd_n), .wp_n_in(wp_n),
    .byte_lanes_in(lanes_w), .byte_lanes_out(d_lanes),
    .byte_lanes_oe_n_out(d_oe_n), .dqs_in(dqs_w),
    .dqs_out(d_dqs), .dqs_oe_n_out(d_dqs_oe_n), .rb_out(rb),
    .rb_oe_n_out(rb_oe_n), .sync_mode_in(sync_mode),
    .rx_out(rx), .rx_valid_out(rx_v), .dout_byte_in(dout),
    .dout_take_out(take), .array_busy_in(busy),
    .prog_erase_req_in(req), .prog_erase_go_out(go),
    .prog_erase_reject_out(rej), .write_protected_out(wprot));

  nand_host_model nand_host_model_i (
    .clk_in(clk), .link_clk_out(link), .ce_n_out(ce_n),
    .cle_out(cle), .ale_out(ale), .rd_n_out(rd_n),
    .lanes_out(h_lanes), .lanes_oe_n_out(h_oe_n),
    .dqs_out(h_dqs), .dqs_oe_n_out(h_dqs_oe_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait for a take or a received-byte pulse
  task automatic wait_on(input logic take_sel);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk) #1;
      if ((take_sel ? take : rx_v) === 1'b1) return;
    end
    error_cnt++;
    $display("MISMATCH at %0t: pulse never came", $time);
    stop_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk) #1;
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_async_wr();
    byte_kind_e k;
    for (int i = 0; i < 3; i++) begin
      k = byte_kind_e'(i);
      nand_host_model_i.wr(k, 8'hA0 + 8'(i), 1'b0);
      wait_on(1'b0);
      chk(16'(rx), {6'h00, k, 8'hA0 + 8'(i)});
    end
  endtask

  task automatic t_refuse();
    nand_host_model_i.wr(KIND_DATA, 8'h77, 1'b1);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      chk(rx_v, 1'b0);
    end
  endtask

  task automatic t_async_rd();
    for (int i = 0; i < 2; i++) begin
      dout = 8'h3C ^ 8'(i * 255);
      nand_host_model_i.rd(1'b0);
      wait_on(1'b1);
      chk(lanes_w, 8'h3C ^ 8'(i * 255));
      chk(d_dqs_oe_n, 1'b1);
      nand_host_model_i.rd(1'b1);
      cyc(5);
      chk(d_oe_n, 1'b1);
    end
  endtask

  task automatic t_prot();
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    chk({go, rej}, 2'h2);
    busy = 1'b1;
    cyc(1);
    chk({rb_w, rb}, 2'h0);
    cyc(4);
    chk(rb_w, 1'b0);
    busy = 1'b0;
    cyc(3);
    chk(rb_w, 1'b1);
    wp_n = 1'b0;
    cyc(4);
    chk(wprot, 1'b1);
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    chk({go, rej}, 2'h1);
    cyc(2);
    chk(rb_w, 1'b1);
    wp_n = 1'b1;
  endtask

  task automatic t_sync();
    logic dq;
    sync_mode = 1'b1;
    // deselected edges carry the mode into the link domain
    repeat (2) nand_host_model_i.wr(KIND_CMD, 8'h00, 1'b1);
    nand_host_model_i.set_dir(1'b1);
    cyc(4);
    nand_host_model_i.wr(KIND_CMD, 8'h5E, 1'b0);
    wait_on(1'b0);
    chk(16'(rx), {6'h00, KIND_CMD, 8'h5E});
    nand_host_model_i.wr(KIND_DATA, 8'h96, 1'b0);
    wait_on(1'b0);
    chk(16'(rx), {6'h00, KIND_DATA, 8'h96});
    nand_host_model_i.set_dir(1'b0);
    cyc(5);
    chk({d_oe_n, d_dqs_oe_n}, 2'h0);
    for (int i = 0; i < 2; i++) begin
      dq = dqs_w;
      dout = 8'h5A + 8'(i);
      nand_host_model_i.pulse();
      wait_on(1'b1);
      chk(lanes_w, 8'h5A + 8'(i));
      chk(dqs_w, !dq);
    end
    nand_host_model_i.set_dir(1'b1);
    cyc(5);
    chk({d_oe_n, d_dqs_oe_n}, 2'h3);
    sync_mode = 1'b0;
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    resetn    = 1'b0;
    wp_n      = 1'b1;
    sync_mode = 1'b0;
    busy      = 1'b0;
    req       = 1'b0;
    dout      = 8'h00;
    repeat (3) nand_host_model_i.pulse();
    cyc(1);
    chk({d_oe_n, d_dqs_oe_n, rb_oe_n, rx_v}, 4'hE);
    resetn = 1'b1;
    cyc(4);
    t_async_wr();
    t_refuse();
    t_async_rd();
    t_prot();
    t_sync();
    stop_test();
  end

  initial begin
    #400000;
    error_cnt++;
    $display("MISMATCH at %0t: run limit reached", $time);
    stop_test();
  end
endmodule
